// ---- adc_serial_config_port_pkg.sv ----
// shared constants and types of the converter serial control port
`default_nettype none
package adc_serial_config_port_pkg;
   // word widths
   localparam int CFG_W = 8;
   localparam int RES_W = 12;
   localparam int WORD_W = 16;
   localparam int LEN_W = 5;
   localparam int RX_W = 4;
   localparam int IDX_W = 4;
   localparam int FIFO_DEPTH = 8;
   // configuration bit positions, first bit shifted in lands at the top
   localparam int CFG_SGL = 7;
   localparam int CFG_ODD = 6;
   localparam int CFG_SEL_HI = 5;
   localparam int CFG_SEL_LO = 4;
   localparam int CFG_UNI = 3;
   localparam int CFG_OUTPUT_ORDER_SEL = 2;
   localparam int CFG_WL_HI = 1;
   localparam int CFG_WL_LO = 0;
   // length codes and lengths in shift-clock cycles
   localparam logic [1:0] WL_8 = 2'h0;
   localparam logic [1:0] WL_OFF = 2'h1;
   localparam logic [1:0] WL_12 = 2'h2;
   localparam logic [1:0] WL_16 = 2'h3;
   localparam logic [LEN_W-1:0] LEN_8 = 5'h08;
   localparam logic [LEN_W-1:0] LEN_OFF = 5'h0A;
   localparam logic [LEN_W-1:0] LEN_12 = 5'h0C;
   localparam logic [LEN_W-1:0] LEN_16 = 5'h10;
   localparam logic [RX_W-1:0] CFG_BITS = 4'h8;
   // synchroniser lanes
   localparam int SYNC_W = 5;
   localparam int SY_CS = 0;
   localparam int SY_SCLK = 1;
   localparam int SY_DIN = 2;
   localparam int SY_ACLK = 3;
   localparam int SY_COMP = 4;
   localparam logic [SYNC_W-1:0] SYNC_RST = 5'h01;
   // chip select settling, in falling conversion-clock edges
   localparam logic [1:0] CS_SETTLE_LAST = 2'h1;
   // successive approximation
   localparam logic [RES_W-1:0] SAR_FIRST = 12'h800;
   localparam logic [IDX_W-1:0] SAR_TOP = 4'hB;
   // sequencers
   typedef enum logic [1:0] {F_IDLE, F_LOAD, F_XFER, F_END} frame_t;
   typedef enum logic [1:0] {C_IDLE, C_SAMPLE, C_SAR, C_PUSH} conv_t;
endpackage : adc_serial_config_port_pkg
`default_nettype wire

// ---- result_fifo.sv ----
// small flip-flop fifo holding finished result words
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [CW-1:0] cnt;
   } fifo_state_t;

   fifo_state_t st_q;
   fifo_state_t st_d;
   logic do_push;
   logic do_pop;

   // honest flags straight from the count
   assign in_ready = (st_q.cnt != FULL);
   assign out_valid = (st_q.cnt != '0);
   assign out_data = st_q.mem[st_q.rd];
   assign do_push = in_valid && in_ready;
   assign do_pop = out_valid && out_ready;

   // pointer wrap handled explicitly so depth need not be a power of two
   always_comb begin
      st_d = st_q;
      if (do_push) begin
         st_d.mem[st_q.wr] = in_data;
         st_d.wr = (st_q.wr == LAST) ? '0 : PW'(st_q.wr + 1'b1);
      end
      if (do_pop) begin
         st_d.rd = (st_q.rd == LAST) ? '0 : PW'(st_q.rd + 1'b1);
      end
      if (do_push && !do_pop) begin
         st_d.cnt = CW'(st_q.cnt + 1'b1);
      end else if (do_pop && !do_push) begin
         st_d.cnt = CW'(st_q.cnt - 1'b1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule : result_fifo
`default_nettype wire

// ---- adc_serial_config_port.sv ----
// serial configuration port and conversion sequencer of the converter
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Serial bits leave on the falling shift-clock edge and are taken on the rising one, both ways.
// - The previous result shifts out while the configuration word shifts in.
// - The requested conversion starts when the exchange ends and chip select should then go high.
// - A result comes out in the transfer after the one that asked for it.
// - The first eight rising shift edges after recognition load the word and later input is ignored.
// - The first four configuration bits form the multiplexer address.
// - In pair mode the select field picks a pair and the odd flag picks which side is positive.
// - In single mode channel two times select plus odd is measured against the shared input.
// - After chip select falls the port waits two falling conversion-clock edges before acting.
// - The shift clock only times transfers and the conversion clock paces the conversion.
// - Bit five picks unipolar at one and bipolar two's complement at zero.
// - Bit six picks most significant first at one and least first at zero, for output only.
// - The last two bits give 8, 12 or 16 output bits, and code 01 powers down.
// - Chip select changes shorter than one conversion-clock period are ignored both ways.
module adc_serial_config_port
   import adc_serial_config_port_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RSTN,
   // serial link pins
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic DIN,
   output logic DOUT,
   output logic DOUT_OE,
   // conversion clock and comparator
   input wire logic ACLK,
   input wire logic COMP,
   // analog front end control
   output logic [2:0] MUX_POS,
   output logic [2:0] MUX_NEG,
   output logic NEG_SHARED,
   output logic SPAN_UNIPOLAR,
   output logic SAMPLE_TRACK,
   output logic [RES_W-1:0] SAR_TRIAL,
   output logic POWER_DOWN
);
   typedef struct packed {
      logic [SYNC_W-1:0] meta;
      logic [SYNC_W-1:0] sync;
      logic sclk_p;
      logic aclk_p;
      logic cs_lvl;
      logic [1:0] settle;
      frame_t frame;
      logic [RX_W-1:0] rx_cnt;
      logic [LEN_W-1:0] tx_cnt;
      logic [CFG_W-1:0] cfg;
      logic [WORD_W-1:0] tx_sh;
      logic dout;
      logic dout_oe;
      conv_t conv;
      logic [IDX_W-1:0] bit_idx;
      logic [RES_W-1:0] sar;
      logic [CFG_W-1:0] conv_cfg;
      logic [2:0] mux_pos;
      logic [2:0] mux_neg;
      logic neg_shared;
      logic unipolar;
      logic track;
      logic pdown;
   } port_state_t;

   localparam port_state_t ST_RST = '{
      meta: SYNC_RST, sync: SYNC_RST, sclk_p: 1'b0, aclk_p: 1'b0,
      cs_lvl: 1'b1, settle: 2'h0, frame: F_IDLE, rx_cnt: 4'h0,
      tx_cnt: 5'h00, cfg: 8'h00, tx_sh: 16'h0000, dout: 1'b0,
      dout_oe: 1'b0, conv: C_IDLE, bit_idx: 4'h0, sar: 12'h000,
      conv_cfg: 8'h00, mux_pos: 3'h0, mux_neg: 3'h0, neg_shared: 1'b0,
      unipolar: 1'b0, track: 1'b0, pdown: 1'b0};

   port_state_t st_q;
   port_state_t st_d;

   // output length for a length code
   function automatic logic [LEN_W-1:0] word_len(input logic [1:0] wl);
      case (wl)
         WL_8: word_len = LEN_8;
         WL_OFF: word_len = LEN_OFF;
         WL_12: word_len = LEN_12;
         default: word_len = LEN_16;
      endcase
   endfunction : word_len

   // bit reversal for the least-significant-first order
   function automatic logic [RES_W-1:0] flip(input logic [RES_W-1:0] v);
      for (int i = 0; i < RES_W; i++) begin
         flip[i] = v[RES_W-1-i];
      end
   endfunction : flip

   // edge finders work only on second-stage synchroniser bits
   logic sclk_rise;
   logic sclk_fall;
   logic aclk_fall;
   logic cs_change;
   logic cs_go_low;
   logic cs_go_high;
   logic end_xfer;
   assign sclk_rise = st_q.sync[SY_SCLK] && !st_q.sclk_p;
   assign sclk_fall = !st_q.sync[SY_SCLK] && st_q.sclk_p;
   assign aclk_fall = !st_q.sync[SY_ACLK] && st_q.aclk_p;
   // a new level needs two falling aclk edges, so it outlives one period
   assign cs_change = (st_q.sync[SY_CS] != st_q.cs_lvl) && aclk_fall &&
      (st_q.settle == CS_SETTLE_LAST);
   assign cs_go_low = cs_change && !st_q.sync[SY_CS];
   assign cs_go_high = cs_change && st_q.sync[SY_CS];
   // exchange ends on the falling edge that completes the chosen length
   assign end_xfer = (st_q.frame == F_XFER) && sclk_fall && !cs_change &&
      (st_q.rx_cnt == CFG_BITS) &&
      (LEN_W'(st_q.tx_cnt + 1'b1) ==
       word_len(st_q.cfg[CFG_WL_HI:CFG_WL_LO]));

   // result path, conversions stall while it is full
   logic push_req;
   logic push_ready;
   logic pop_req;
   logic pop_valid;
   logic [WORD_W-1:0] push_word;
   logic [WORD_W-1:0] pop_word;
   logic [RES_W-1:0] code;
   assign push_req = (st_q.conv == C_PUSH);
   assign pop_req = (st_q.frame == F_LOAD) && !cs_change;
   // bipolar results leave as two's complement by flipping the msb
   assign code = st_q.conv_cfg[CFG_UNI] ? st_q.sar :
      {~st_q.sar[RES_W-1], st_q.sar[RES_W-2:0]};
   // word is pre-ordered so the shifter always sends bit 15 first
   assign push_word = st_q.conv_cfg[CFG_OUTPUT_ORDER_SEL] ? {code, 4'h0} :
      {flip(code), 4'h0};

   result_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(DEPTH)
   ) u_results (
      .clk(MCLK),
      .rst_n(RSTN),
      .in_valid(push_req),
      .in_ready(push_ready),
      .in_data(push_word),
      .out_valid(pop_valid),
      .out_ready(pop_req),
      .out_data(pop_word)
   );

   // next state of the whole port
   always_comb begin
      st_d = st_q;
      st_d.meta = {COMP, ACLK, DIN, SCLK, CS_N};
      st_d.sync = st_q.meta;
      st_d.sclk_p = st_q.sync[SY_SCLK];
      st_d.aclk_p = st_q.sync[SY_ACLK];
      // chip select deglitcher
      if (st_q.sync[SY_CS] == st_q.cs_lvl) begin
         st_d.settle = 2'h0;
      end else if (cs_change) begin
         st_d.cs_lvl = st_q.sync[SY_CS];
         st_d.settle = 2'h0;
      end else if (aclk_fall) begin
         st_d.settle = 2'(st_q.settle + 1'b1);
      end
      // conversion, paced only by the conversion clock
      case (st_q.conv)
         C_IDLE: begin
         end
         C_SAMPLE: begin
            if (aclk_fall) begin
               st_d.track = 1'b0;
               st_d.sar = SAR_FIRST;
               st_d.bit_idx = SAR_TOP;
               st_d.conv = C_SAR;
            end
         end
         C_SAR: begin
            if (aclk_fall) begin
               st_d.sar[st_q.bit_idx] = st_q.sync[SY_COMP];
               if (st_q.bit_idx == '0) begin
                  st_d.conv = C_PUSH;
               end else begin
                  st_d.sar[IDX_W'(st_q.bit_idx - 1'b1)] = 1'b1;
                  st_d.bit_idx = IDX_W'(st_q.bit_idx - 1'b1);
               end
            end
         end
         C_PUSH: begin
            if (push_ready) begin
               st_d.conv = C_IDLE;
            end
         end
         default: st_d.conv = C_IDLE;
      endcase
      // transfer framing, shift clock ignored while select is high
      if (cs_go_high) begin
         st_d.frame = F_IDLE;
         st_d.dout_oe = 1'b0;
      end else if (cs_go_low) begin
         st_d.frame = F_LOAD;
         st_d.pdown = 1'b0;
         st_d.rx_cnt = '0;
         st_d.tx_cnt = '0;
         st_d.cfg = '0;
      end else begin
         case (st_q.frame)
            F_IDLE: begin
            end
            F_LOAD: begin
               // previous result, or zeros when none was asked for
               if (pop_valid) begin
                  st_d.tx_sh = pop_word;
                  st_d.dout = pop_word[WORD_W-1];
                  st_d.dout_oe = 1'b1;
                  st_d.frame = F_XFER;
               end else if (st_q.conv == C_IDLE) begin
                  st_d.tx_sh = '0;
                  st_d.dout = 1'b0;
                  st_d.dout_oe = 1'b1;
                  st_d.frame = F_XFER;
               end
            end
            F_XFER: begin
               if (sclk_rise && (st_q.rx_cnt != CFG_BITS)) begin
                  // first bit in ends up at the top of the word
                  st_d.cfg = {st_q.cfg[CFG_W-2:0], st_q.sync[SY_DIN]};
                  st_d.rx_cnt = RX_W'(st_q.rx_cnt + 1'b1);
               end
               if (sclk_fall) begin
                  st_d.tx_sh = {st_q.tx_sh[WORD_W-2:0], 1'b0};
                  st_d.dout = st_q.tx_sh[WORD_W-2];
                  st_d.tx_cnt = LEN_W'(st_q.tx_cnt + 1'b1);
               end
               if (end_xfer) begin
                  st_d.frame = F_END;
                  if (st_q.cfg[CFG_WL_HI:CFG_WL_LO] == WL_OFF) begin
                     st_d.pdown = 1'b1;
                  end else begin
                     // mux address set from the word just received
                     st_d.conv = C_SAMPLE;
                     st_d.track = 1'b1;
                     st_d.conv_cfg = st_q.cfg;
                     st_d.unipolar = st_q.cfg[CFG_UNI];
                     st_d.mux_pos = {st_q.cfg[CFG_SEL_HI:CFG_SEL_LO],
                        st_q.cfg[CFG_ODD]};
                     st_d.neg_shared = st_q.cfg[CFG_SGL];
                     st_d.mux_neg = st_q.cfg[CFG_SGL] ? 3'h0 :
                        {st_q.cfg[CFG_SEL_HI:CFG_SEL_LO],
                         ~st_q.cfg[CFG_ODD]};
                  end
               end
            end
            F_END: begin
            end
            default: st_d.frame = F_IDLE;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign DOUT = st_q.dout;
   assign DOUT_OE = st_q.dout_oe;
   assign MUX_POS = st_q.mux_pos;
   assign MUX_NEG = st_q.mux_neg;
   assign NEG_SHARED = st_q.neg_shared;
   assign SPAN_UNIPOLAR = st_q.unipolar;
   assign SAMPLE_TRACK = st_q.track;
   assign SAR_TRIAL = st_q.sar;
   assign POWER_DOWN = st_q.pdown;

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RSTN);

   sequence s_cs_settled_low;
      !st_q.sync[SY_CS] && st_q.cs_lvl && aclk_fall &&
         (st_q.settle == CS_SETTLE_LAST);
   endsequence
   sequence s_port_opened;
      !st_q.cs_lvl && (st_q.frame == F_LOAD);
   endsequence

   a_cs_recog_low: assert property (s_cs_settled_low |=> s_port_opened)
      else $error("chip select low not recognised after settling");
   a_cs_glitch_ignored: assert property ($changed(st_q.cs_lvl) |->
      $past(aclk_fall) && ($past(st_q.settle) == CS_SETTLE_LAST))
      else $error("chip select level taken without two aclk falls");
   a_cfg_bit_taken: assert property ((st_q.frame == F_XFER) && sclk_rise &&
      !cs_change && (st_q.rx_cnt < CFG_BITS) |=>
      (st_q.cfg[0] == $past(st_q.sync[SY_DIN])))
      else $error("configuration bit not taken on rising edge");
   a_cfg_count_cap: assert property ((st_q.rx_cnt == CFG_BITS) &&
      (st_q.frame == F_XFER) && !cs_change |=> $stable(st_q.cfg))
      else $error("input taken after eight bits");
   a_dout_on_fall: assert property ((st_q.frame == F_XFER) && !sclk_fall
      |=> $stable(st_q.dout))
      else $error("output bit changed away from a falling edge");
   a_conv_start: assert property (end_xfer &&
      (st_q.cfg[CFG_WL_HI:CFG_WL_LO] != WL_OFF) |=>
      (st_q.conv == C_SAMPLE) && st_q.track ##1 st_q.conv != C_IDLE)
      else $error("conversion did not start at end of exchange");
   a_shutdown_code: assert property (end_xfer &&
      (st_q.cfg[CFG_WL_HI:CFG_WL_LO] == WL_OFF) |=>
      st_q.pdown && (st_q.conv == C_IDLE))
      else $error("shutdown code did not power down");
   a_sar_paced: assert property ((st_q.conv == C_SAR) && !aclk_fall
      |=> $stable(st_q.sar))
      else $error("approximation stepped without conversion clock");
   a_mux_single: assert property ((st_q.conv == C_SAMPLE) &&
      st_q.conv_cfg[CFG_SGL] |-> st_q.neg_shared && (st_q.mux_pos ==
      {st_q.conv_cfg[CFG_SEL_HI:CFG_SEL_LO], st_q.conv_cfg[CFG_ODD]}))
      else $error("single channel selection wrong");
   a_mux_pair: assert property ((st_q.conv == C_SAMPLE) &&
      !st_q.conv_cfg[CFG_SGL] |-> !st_q.neg_shared &&
      (st_q.mux_pos[2:1] == st_q.mux_neg[2:1]) &&
      (st_q.mux_pos[0] == st_q.conv_cfg[CFG_ODD]) &&
      (st_q.mux_neg[0] == !st_q.conv_cfg[CFG_ODD]))
      else $error("pair selection wrong");
   a_out_lag: assert property (pop_req && pop_valid |=>
      (st_q.tx_sh == $past(pop_word)) && st_q.dout_oe)
      else $error("stored result not loaded for output");
   a_push_order: assert property (push_req && st_q.conv_cfg[CFG_UNI] |->
      (st_q.conv_cfg[CFG_OUTPUT_ORDER_SEL] ? (push_word[15:4] == st_q.sar) :
      (push_word[4] == st_q.sar[RES_W-1])))
      else $error("output order wrong");
   a_push_bipolar: assert property (push_req && !st_q.conv_cfg[CFG_UNI] &&
      st_q.conv_cfg[CFG_OUTPUT_ORDER_SEL] |-> (push_word[15] != st_q.sar[RES_W-1]))
      else $error("bipolar code not two's complement");
endmodule : adc_serial_config_port
`default_nettype wire

// ---- host_link_model.sv ----
// host-side model that drives the serial link of the converter port
`timescale 1ns/1ns
`default_nettype none
module host_link_model #(
   parameter int ACLK_CYC = 6
) (
   // system clock
   input wire logic mclk,
   // serial link
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   logic [15:0] rx_word;
   logic rx_ok;
   logic early;
   event rx_done;

   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end

   // short low pulse on chip select, well under one conversion clock
   task automatic glitch(input int cycles);
      cs_n <= 1'b0;
      repeat (cycles) @(posedge mclk);
      cs_n <= 1'b1;
   endtask : glitch

   // one full exchange: select, wait for the port, n shift cycles
   task automatic xfer(input logic [7:0] cfg, input int n);
      int k;
      rx_ok = 1'b1;
      rx_word = 16'h0000;
      cs_n <= 1'b0;
      repeat (5) @(posedge mclk);
      early = dout_oe;
      k = 0;
      // no shift edge before the port shows it is listening
      while (dout_oe !== 1'b1 && k < 600) begin
         @(posedge mclk);
         k++;
      end
      if (dout_oe !== 1'b1) rx_ok = 1'b0;
      repeat (2) @(posedge mclk);
      // half periods of four system cycles give the 400 ns shift clock
      for (int i = 0; i < n; i++) begin
         din <= (i < 8) ? cfg[7 - i] : ~din;
         repeat (4) @(posedge mclk);
         sclk <= 1'b1;
         // a released line reads as the inverse of its last level
         rx_word = {rx_word[14:0], dout_oe ? dout : ~dout};
         repeat (4) @(posedge mclk);
         sclk <= 1'b0;
      end
      cs_n <= 1'b1;
      ->rx_done;
      // data line is not left at a steady level between frames
      repeat (52 * ACLK_CYC) @(posedge mclk) din <= ~din;
   endtask : xfer
endmodule : host_link_model
`default_nettype wire

// ---- adc_serial_config_port_tb.sv ----
// self-checking bench for the converter serial control port
`timescale 1ns/1ns
`default_nettype none
module adc_serial_config_port_tb;
   import adc_serial_config_port_pkg::*;
   logic mclk = 1'b0;
   logic aclk = 1'b0;
   logic comp = 1'b0;
   logic trk_prev = 1'b0;
   logic rstn, prev_ok, prev_output_order_sel;
   logic cs_n, sclk, din, dout, dout_oe, neg_shared, span_uni, track, pdn;
   logic [2:0] mux_pos, mux_neg;
   logic [1:0] acnt = 2'h0;
   logic [15:0] fe_now;
   logic [RES_W-1:0] sar_trial, vin, prev_code;
   logic [15:0] exp_q[$];
   logic [7:0] fe_q[$];
   int num_errors = 0;
   int checked = 0;
   int cyc = 0;
   int seed = 32'h4306;

   adc_serial_config_port #(.DEPTH(FIFO_DEPTH)) uut (
      .MCLK(mclk), .RSTN(rstn), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
      .DOUT(dout), .DOUT_OE(dout_oe), .ACLK(aclk), .COMP(comp),
      .MUX_POS(mux_pos), .MUX_NEG(mux_neg), .NEG_SHARED(neg_shared),
      .SPAN_UNIPOLAR(span_uni), .SAMPLE_TRACK(track),
      .SAR_TRIAL(sar_trial), .POWER_DOWN(pdn));

   host_link_model #(.ACLK_CYC(6)) u_host (
      .mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
      .dout_oe(dout_oe));

   always #25 mclk = ~mclk;

   // conversion clock at six system cycles; comparator follows the trial
   always @(posedge mclk) begin
      acnt <= (acnt == 2'h2) ? 2'h0 : acnt + 2'h1;
      if (acnt == 2'h2) aclk <= ~aclk;
      comp <= (sar_trial <= vin);
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic close_out;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] expd);
      checked++;
      if (seen !== expd) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, expd, seen);
      end
   endtask : check

   function automatic logic [RES_W-1:0] rev12(input logic [RES_W-1:0] v);
      for (int i = 0; i < RES_W; i++) rev12[i] = v[RES_W - 1 - i];
   endfunction : rev12

   // mux, negative side and span that a word asks for
   function automatic logic [7:0] fe_exp(input logic [7:0] c);
      logic [2:0] pos;
      pos = {c[5:4], c[6]};
      return c[7] ? {pos, 3'h0, 1'b1, c[3]} : {pos, c[5:4], ~c[6], 1'b0, c[3]};
   endfunction : fe_exp

   // shift cycles that a length code asks for
   function automatic int len_of(input logic [1:0] l);
      case (l)
         WL_8: return 8;
         WL_OFF: return 10;
         WL_12: return 12;
         default: return 16;
      endcase
   endfunction : len_of

   // result word watcher
   initial begin
      forever begin
         @(u_host.rx_done);
         check("open", {14'h0, u_host.rx_ok, u_host.early}, 16'h2);
         if (exp_q.size() > 0)
            check("result", u_host.rx_word, exp_q.pop_front());
      end
   end

   // front end settings watched where sampling starts
   assign fe_now = {8'h0, mux_pos, mux_neg, neg_shared, span_uni};
   always @(posedge mclk) begin
      if (track === 1'b1 && trk_prev !== 1'b1 && fe_q.size() > 0)
         check("mux", fe_now, {8'h0, fe_q.pop_front()});
      trk_prev <= track;
   end

   // one exchange with expectations noted before it starts
   task automatic frame(input logic [7:0] c);
      int n;
      logic [15:0] w;
      n = len_of(c[1:0]);
      w = prev_output_order_sel ? {prev_code, 4'h0} : {rev12(prev_code), 4'h0};
      if (!prev_ok) w = 16'h0000;
      exp_q.push_back(w >> (16 - n));
      if (c[1:0] != WL_OFF) fe_q.push_back(fe_exp(c));
      vin = 12'($random(seed));
      u_host.xfer(c, n);
      check("released", {15'h0, dout_oe}, 16'h0);
      check("shutdown", {15'h0, pdn}, {15'h0, c[1:0] == WL_OFF});
      prev_ok = (c[1:0] != WL_OFF);
      prev_output_order_sel = c[2];
      prev_code = c[3] ? vin : vin ^ 12'h800;
   endtask : frame

   // main sequence
   initial begin
      logic [7:0] c;
      rstn = 1'b0;
      vin = 12'h000;
      prev_ok = 1'b0;
      prev_output_order_sel = 1'b1;
      prev_code = 12'h000;
      repeat (8) @(posedge mclk);
      check("reset oe", {15'h0, dout_oe}, 16'h0);
      check("reset pdn", {15'h0, pdn}, 16'h0);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      // a chip select blip must not open a frame
      u_host.glitch(3);
      repeat (40) @(posedge mclk);
      check("glitch", {15'h0, dout_oe}, 16'h0);
      // every mux address with random type, order and length
      for (int a = 0; a < 16; a++) begin
         c = {a[3:0], 4'($random(seed))};
         if (c[1:0] == WL_OFF) c[1:0] = WL_16;
         frame(c);
      end
      // every length code in both orders, shutdown included
      for (int l = 0; l < 4; l++) begin
         for (int m = 0; m < 2; m++) begin
            c = {5'($random(seed)), m[0], l[1:0]};
            frame(c);
         end
      end
      frame(8'hEF);
      close_out();
   end
endmodule : adc_serial_config_port_tb
`default_nettype wire
